// ---- core/iocp_regs.vh ----
// Constants for the input counter and output modulation block
// Summary of operation
// R1 - Twelve inputs mapped onto timer blocks 0-3,6,7
// R2 - Output pairs mapped onto timer blocks 2-5
// R3 - Conflicting block setting reports error, not applied
// R4 - Any input: interrupt, counter or capture
// R5 - Quadrature uses two/three pins of one block
// R6 - Interrupt edge: rising, falling or both
// R7 - Counter counts up or down on chosen edges
// R8 - Capture latches timestamp at event start and end
// R9 - Clear command resets an event counter
// R10 - Start and stop stamps read separately
// R11 - Eight outputs sink low or release line
// R12 - Outputs released after reset until enabled
// R13 - Outputs in one block share one period
// R14 - Noninverted width mod: high, then low
// R15 - Inverted width mod: low, then high
// R16 - Width mod starts on trigger, block edges aligned
// R17 - Position mod delayed by offset after trigger
// R18 - Position mod inverted by starting level, aligned
// R19 - Quadrature steps by phase order; index clears
`ifndef IOCP_REGS_VH
`define IOCP_REGS_VH
`define IOCP_NIN 12
`define IOCP_NOUT 8
`define IOCP_W 16
`define IOCP_ZERO 16'h0000
`define IOCP_ONE 16'h0001
// Command operations
`define IOCP_OP_IN 2'h0
`define IOCP_OP_OUT 2'h1
`define IOCP_OP_CLR 2'h2
// Input modes
`define IOCP_IM_OFF 3'h0
`define IOCP_IM_IRQ 3'h1
`define IOCP_IM_CNT 3'h2
`define IOCP_IM_CAP 3'h3
`define IOCP_IM_QUAD 3'h4
// Output modes
`define IOCP_OM_OFF 2'h0
`define IOCP_OM_STAT 2'h1
`define IOCP_OM_PWM 2'h2
`define IOCP_OM_PPM 2'h3
// Block usage categories
`define IOCP_CAT_NONE 2'h0
`define IOCP_CAT_EV 2'h1
`define IOCP_CAT_QD 2'h2
`define IOCP_CAT_PW 2'h3
// Timer block numbers and last channel numbers
`define IOCP_BLK0 3'h0
`define IOCP_BLK1 3'h1
`define IOCP_BLK2 3'h2
`define IOCP_BLK3 3'h3
`define IOCP_BLK6 3'h6
`define IOCP_BLK7 3'h7
`define IOCP_OBLK_BASE 3'h2
`define IOCP_LAST_IN 4'hB
`define IOCP_LAST_OUT 4'h7
`endif

// ---- core/iocp_pwm_blk.v ----
// Shared-period waveform generator for one output timer block
`timescale 1ns/10ps
module iocp_pwm_blk (
  input wire clk,
  input wire ce,
  input wire rst_b,
  input wire trig,
  input wire restart,
  input wire [15:0] period,
  input wire [3:0] mode,
  input wire [1:0] inv,
  input wire [31:0] duty,
  input wire [31:0] offs,
  output reg [1:0] oe_b_q
);
`include "iocp_regs.vh"
  reg [15:0] ph_q; // Shared phase counter, keeps edges aligned
  reg run_q; // Set by the trigger
  wire [15:0] last = (period == `IOCP_ZERO) ? `IOCP_ZERO : period - `IOCP_ONE;
  genvar k;

  // One counter for both outputs so their edges line up
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q <= `IOCP_ZERO;
      run_q <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        // Reconfigured: halt, but keep a trigger that lands on this same edge
        run_q <= trig; // R16
        ph_q <= `IOCP_ZERO;
      end else if (!run_q) begin
        if (trig) begin
          run_q <= 1'b1; // R16
          ph_q <= `IOCP_ZERO;
        end
      end else if (ph_q >= last) begin
        ph_q <= `IOCP_ZERO; // R13
      end else begin
        ph_q <= ph_q + `IOCP_ONE;
      end
    end
  end

  generate
    for (k = 0; k < 2; k = k + 1) begin : g_out
      wire [1:0] m = mode[2*k+:2];
      wire [15:0] d = duty[16*k+:16];
      wire [15:0] o = offs[16*k+:16];
      wire [15:0] rel = ph_q - o;
      wire act_w = ph_q < d; // R14
      wire act_p = (ph_q >= o) && (rel < d); // R17
      reg lvl;
      // Waveform level, high means sinking
      always @* begin
        case (m)
          `IOCP_OM_STAT: lvl = inv[k];
          `IOCP_OM_PWM: lvl = run_q & (act_w ^ inv[k]); // R15
          `IOCP_OM_PPM: lvl = run_q & (act_p ^ inv[k]); // R18
          default: lvl = 1'b0;
        endcase
      end
      // Registered enable, low pulls the line down
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          oe_b_q[k] <= 1'b1; // R12
        end else if (ce) begin
          oe_b_q[k] <= ~lvl; // R11
        end
      end
    end
  endgenerate
endmodule

// ---- core/iocp_top.v ----
// Input event counting, capture, quadrature and output modulation core
`timescale 1ns/10ps
module iocp_top (
  input wire CLK,
  input wire CE,
  input wire RST_B,
  input wire [11:0] IN_PIN,
  input wire CMD_VALID,
  input wire [1:0] CMD_OP,
  input wire [3:0] CMD_CHAN,
  input wire [2:0] CMD_MODE,
  input wire [1:0] CMD_EDGE,
  input wire CMD_DOWN,
  input wire CMD_INDEX,
  input wire [3:0] CMD_STOP,
  input wire CMD_INV,
  input wire [15:0] CMD_PERIOD,
  input wire [15:0] CMD_DUTY,
  input wire [15:0] CMD_OFFSET,
  input wire [3:0] OUT_TRIG,
  input wire [3:0] RD_CHAN,
  output reg CMD_DONE,
  output reg CMD_CONFLICT,
  output reg [11:0] IN_IRQ,
  output reg [15:0] RD_COUNT,
  output reg [15:0] RD_BEGIN,
  output reg [15:0] RD_END,
  output reg RD_CAP_DONE,
  output reg [7:0] OUT_DO,
  output wire [7:0] OUT_OE_B
);
`include "iocp_regs.vh"

  // Input pin to timer block map
  function [2:0] in_blk;
    input [3:0] c;
    begin
      if (c < 4'h3) in_blk = `IOCP_BLK0; // R1
      else if (c < 4'h6) in_blk = `IOCP_BLK1;
      else if (c < 4'h8) in_blk = `IOCP_BLK2;
      else if (c < 4'hA) in_blk = `IOCP_BLK3;
      else if (c == 4'hA) in_blk = `IOCP_BLK6;
      else in_blk = `IOCP_BLK7;
    end
  endfunction

  // Output pairs sit on blocks 2 to 5
  function [2:0] out_blk;
    input [3:0] c;
    begin
      out_blk = `IOCP_OBLK_BASE + {1'b0, c[2:1]}; // R2
    end
  endfunction

  // Edge select: bit 0 rising, bit 1 falling
  function edge_hit;
    input [1:0] e;
    input r;
    input f;
    begin
      edge_hit = (e[0] & r) | (e[1] & f); // R6
    end
  endfunction

  // Input synchroniser, third stage only for edge detection
  reg [11:0] s1_q;
  reg [11:0] s2_q;
  reg [11:0] s3_q;
  reg [15:0] ts_q; // Free-running timestamp
  wire [11:0] rise = s2_q & ~s3_q;
  wire [11:0] fall = ~s2_q & s3_q;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      s1_q <= 12'h000;
      s2_q <= 12'h000;
      s3_q <= 12'h000;
      ts_q <= `IOCP_ZERO;
    end else if (CE) begin
      s1_q <= IN_PIN;
      s2_q <= s1_q;
      s3_q <= s2_q;
      ts_q <= ts_q + `IOCP_ONE;
    end
  end

  // Flattened per-channel state for muxing and conflict checks
  wire [35:0] imode_w;
  wire [191:0] cnt_w;
  wire [191:0] beg_w;
  wire [191:0] end_w;
  wire [11:0] cdone_w;
  wire [11:0] irq_w;
  reg [15:0] omode_flat_q; // Two bits per output
  reg [7:0] oinv_q;
  reg [127:0] oduty_q;
  reg [127:0] ooff_q;
  reg [63:0] bper_q; // One period per output block
  reg [3:0] restart_q;

  // Command decode
  wire op_in = CMD_OP == `IOCP_OP_IN;
  wire op_out = CMD_OP == `IOCP_OP_OUT;
  wire op_clr = CMD_OP == `IOCP_OP_CLR;
  wire [3:0] c1 = CMD_CHAN + 4'h1;
  wire [3:0] c2 = CMD_CHAN + 4'h2;
  wire [2:0] tblk = op_out ? out_blk(CMD_CHAN) : in_blk(CMD_CHAN);
  wire [1:0] oslot = CMD_CHAN[2:1];
  wire [1:0] new_om = CMD_MODE[1:0];
  reg [1:0] new_cat;
  reg conflict;
  reg [1:0] cat;
  integer j;

  // Requested usage and clash with the rest of the block
  always @* begin
    conflict = 1'b0;
    cat = `IOCP_CAT_NONE;
    new_cat = `IOCP_CAT_NONE;
    if (op_in) begin
      if (CMD_MODE == `IOCP_IM_QUAD) new_cat = `IOCP_CAT_QD;
      else if (CMD_MODE != `IOCP_IM_OFF) new_cat = `IOCP_CAT_EV; // R4
    end else if (op_out) begin
      if (new_om[1]) new_cat = `IOCP_CAT_PW;
    end
    if (op_in || op_clr) begin
      if (CMD_CHAN > `IOCP_LAST_IN) conflict = 1'b1;
    end else if (op_out) begin
      if (CMD_CHAN > `IOCP_LAST_OUT) conflict = 1'b1;
    end else begin
      conflict = 1'b1;
    end
    // Partner pins must live in the same block
    if (new_cat == `IOCP_CAT_QD) begin
      if (CMD_CHAN >= `IOCP_LAST_IN || in_blk(c1) != tblk) conflict = 1'b1; // R5
      if (CMD_INDEX && (c1 >= `IOCP_LAST_IN || in_blk(c2) != tblk)) conflict = 1'b1; // R5
    end
    for (j = 0; j < 12; j = j + 1) begin
      if (!(op_in && CMD_CHAN == j) && in_blk(j[3:0]) == tblk) begin
        if (imode_w[3*j+:3] == `IOCP_IM_QUAD) cat = `IOCP_CAT_QD;
        else if (imode_w[3*j+:3] != `IOCP_IM_OFF) cat = `IOCP_CAT_EV;
        else cat = `IOCP_CAT_NONE;
        if (new_cat != `IOCP_CAT_NONE && cat != `IOCP_CAT_NONE && cat != new_cat) conflict = 1'b1; // R3
      end
    end
    for (j = 0; j < 8; j = j + 1) begin
      if (!(op_out && CMD_CHAN == j) && out_blk(j[3:0]) == tblk && omode_flat_q[2*j+1]) begin
        if (new_cat != `IOCP_CAT_NONE && new_cat != `IOCP_CAT_PW) conflict = 1'b1; // R3
        if (new_cat == `IOCP_CAT_PW && bper_q[16*j[2:1]+:16] != CMD_PERIOD) conflict = 1'b1; // R13
      end
    end
  end

  wire accept = CMD_VALID & ~conflict;

  // Per-input event logic
  genvar i;
  generate
    for (i = 0; i < 12; i = i + 1) begin : g_in
      localparam integer PA = (i + 1) % 12; // Phase B partner
      localparam integer PI = (i + 2) % 12; // Index partner
      reg [2:0] mode_q;
      reg [1:0] edge_q;
      reg down_q;
      reg idx_q;
      reg [3:0] stop_q;
      reg [15:0] cnt_q;
      reg [15:0] beg_q;
      reg [15:0] end_q;
      reg run_q; // Capture waiting for stop edge
      reg done_q; // Capture pair complete
      reg irq_q;
      wire wr = accept & op_in & (CMD_CHAN == i);
      wire clr = accept & op_clr & (CMD_CHAN == i);
      wire hit = edge_hit(edge_q, rise[i], fall[i]);
      wire shit = edge_hit(edge_q, rise[stop_q], fall[stop_q]);
      // Quadrature phases, partner wraps only where conflict check forbids use
      wire qa = s2_q[i];
      wire qb = s2_q[PA];
      wire qa_p = s3_q[i];
      wire qb_p = s3_q[PA];
      wire qstep = (qa ^ qa_p) ^ (qb ^ qb_p);
      wire qup = qa ^ qb_p;
      wire qidx = idx_q & s2_q[PI];

      always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
          mode_q <= `IOCP_IM_OFF;
          edge_q <= 2'h0;
          down_q <= 1'b0;
          idx_q <= 1'b0;
          stop_q <= 4'h0;
          cnt_q <= `IOCP_ZERO;
          beg_q <= `IOCP_ZERO;
          end_q <= `IOCP_ZERO;
          run_q <= 1'b0;
          done_q <= 1'b0;
          irq_q <= 1'b0;
        end else if (CE) begin
          irq_q <= 1'b0;
          if (wr) begin
            // New setting also restarts the channel
            mode_q <= CMD_MODE;
            edge_q <= CMD_EDGE;
            down_q <= CMD_DOWN;
            idx_q <= CMD_INDEX;
            stop_q <= (CMD_STOP > `IOCP_LAST_IN) ? CMD_CHAN : CMD_STOP;
            cnt_q <= `IOCP_ZERO;
            run_q <= 1'b0;
            done_q <= 1'b0;
          end else if (clr) begin
            cnt_q <= `IOCP_ZERO; // R9
            beg_q <= `IOCP_ZERO;
            end_q <= `IOCP_ZERO;
            run_q <= 1'b0;
            done_q <= 1'b0;
          end else begin
            case (mode_q)
              `IOCP_IM_IRQ: irq_q <= hit; // R6
              `IOCP_IM_CNT: begin
                if (hit) cnt_q <= down_q ? cnt_q - `IOCP_ONE : cnt_q + `IOCP_ONE; // R7
              end
              `IOCP_IM_CAP: begin
                if (!run_q && hit) begin
                  beg_q <= ts_q; // R8
                  run_q <= 1'b1;
                  done_q <= 1'b0;
                end else if (run_q && shit) begin
                  end_q <= ts_q; // R8
                  run_q <= 1'b0;
                  done_q <= 1'b1;
                end
              end
              `IOCP_IM_QUAD: begin
                if (qidx) cnt_q <= `IOCP_ZERO; // R19
                else if (qstep) cnt_q <= qup ? cnt_q + `IOCP_ONE : cnt_q - `IOCP_ONE; // R19
              end
              default: irq_q <= 1'b0;
            endcase
          end
        end
      end
      assign imode_w[3*i+:3] = mode_q;
      assign cnt_w[16*i+:16] = cnt_q;
      assign beg_w[16*i+:16] = beg_q;
      assign end_w[16*i+:16] = end_q;
      assign cdone_w[i] = done_q;
      assign irq_w[i] = irq_q;
    end
  endgenerate

  // Output configuration store
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      omode_flat_q <= 16'h0000; // R12
      oinv_q <= 8'h00;
      oduty_q <= 128'h0;
      ooff_q <= 128'h0;
      bper_q <= 64'h0;
      restart_q <= 4'h0;
    end else if (CE) begin
      restart_q <= 4'h0;
      if (accept && op_out) begin
        omode_flat_q[2*CMD_CHAN[2:0]+:2] <= new_om;
        oinv_q[CMD_CHAN[2:0]] <= CMD_INV;
        oduty_q[16*CMD_CHAN[2:0]+:16] <= CMD_DUTY;
        ooff_q[16*CMD_CHAN[2:0]+:16] <= CMD_OFFSET;
        restart_q[oslot] <= 1'b1;
        if (new_om[1]) bper_q[16*oslot+:16] <= CMD_PERIOD; // R13
      end
    end
  end

  // One waveform engine per output block, pairs share the period
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_blk
      iocp_pwm_blk u_pwm (
        .clk(CLK),
        .ce(CE),
        .rst_b(RST_B),
        .trig(OUT_TRIG[b]),
        .restart(restart_q[b]),
        .period(bper_q[16*b+:16]),
        .mode(omode_flat_q[4*b+:4]),
        .inv(oinv_q[2*b+:2]),
        .duty(oduty_q[32*b+:32]),
        .offs(ooff_q[32*b+:32]),
        .oe_b_q(OUT_OE_B[2*b+:2])
      );
    end
  endgenerate

  // Answers, interrupts and readback
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CMD_DONE <= 1'b0;
      CMD_CONFLICT <= 1'b0;
      IN_IRQ <= 12'h000;
      RD_COUNT <= `IOCP_ZERO;
      RD_BEGIN <= `IOCP_ZERO;
      RD_END <= `IOCP_ZERO;
      RD_CAP_DONE <= 1'b0;
      OUT_DO <= 8'h00; // R11
    end else if (CE) begin
      CMD_DONE <= accept;
      CMD_CONFLICT <= CMD_VALID & conflict; // R3
      IN_IRQ <= irq_w;
      OUT_DO <= 8'h00; // Line only ever pulled low
      // Out-of-range index reads as zero
      if (RD_CHAN > `IOCP_LAST_IN) begin
        RD_COUNT <= `IOCP_ZERO;
        RD_BEGIN <= `IOCP_ZERO;
        RD_END <= `IOCP_ZERO;
        RD_CAP_DONE <= 1'b0;
      end else begin
        RD_COUNT <= cnt_w[16*RD_CHAN+:16];
        RD_BEGIN <= beg_w[16*RD_CHAN+:16]; // R10
        RD_END <= end_w[16*RD_CHAN+:16]; // R10
        RD_CAP_DONE <= cdone_w[RD_CHAN];
      end
    end
  end
endmodule

// ---- tb/iocp_top_monitor.sv ----
// Concurrent checks on the ports of the counter and modulation core
`timescale 1ns/10ps
module iocp_chk (
  input logic CLK,
  input logic CE,
  input logic RST_B,
  input logic [11:0] IN_PIN,
  input logic CMD_VALID,
  input logic [1:0] CMD_OP,
  input logic [3:0] CMD_CHAN,
  input logic [2:0] CMD_MODE,
  input logic [3:0] OUT_TRIG,
  input logic [3:0] RD_CHAN,
  input logic CMD_DONE,
  input logic CMD_CONFLICT,
  input logic [11:0] IN_IRQ,
  input logic [15:0] RD_COUNT,
  input logic RD_CAP_DONE,
  input logic [7:0] OUT_DO,
  input logic [7:0] OUT_OE_B
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Last pin levels and cycles since any pin moved
  logic [11:0] pin_q;
  logic [3:0] age_q;
  // Command strobe, whether accepted or refused
  wire cmd_w = CE && CMD_VALID;
  // Age saturates so a long quiet spell never wraps back into range
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_q <= 12'h000;
      age_q <= 4'hF;
    end else begin
      pin_q <= IN_PIN;
      if (IN_PIN != pin_q) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
    end
  end
  // Clear of the channel on view, then its acceptance
  sequence s_clr;
    cmd_w && CMD_OP == 2'h2 && CMD_CHAN == RD_CHAN && CMD_CHAN < 4'hC ##1 CMD_DONE;
  endsequence
  // Width mod set on output 2, then its acceptance
  sequence s_cfg2;
    cmd_w && CMD_OP == 2'h1 && CMD_CHAN == 4'h2 && CMD_MODE[1:0] == 2'h2 ##1 CMD_DONE;
  endsequence
  AST_RESET_OUT: assert property ($rose(RST_B) |-> OUT_OE_B == 8'hFF && !CMD_DONE)
    else $error("outputs not released after reset");
  AST_SINK_ONLY: assert property (OUT_DO == 8'h00)
    else $error("output data not low");
  AST_ONE_ANSWER: assert property (cmd_w |=> CMD_DONE != CMD_CONFLICT)
    else $error("command not answered once");
  AST_QUIET: assert property (!cmd_w |=> !CMD_DONE && !CMD_CONFLICT)
    else $error("answer without command");
  AST_BAD_OP: assert property (cmd_w && CMD_OP == 2'h3 |=> CMD_CONFLICT)
    else $error("unknown operation accepted");
  AST_BAD_IN: assert property (cmd_w && CMD_OP == 2'h0 && CMD_CHAN > 4'hB |=> CMD_CONFLICT)
    else $error("input channel out of range accepted");
  AST_BAD_OUT: assert property (cmd_w && CMD_OP == 2'h1 && CMD_CHAN > 4'h7 |=> CMD_CONFLICT)
    else $error("output channel out of range accepted");
  AST_QUAD_SPLIT: assert property (cmd_w && CMD_OP == 2'h0 && CMD_MODE == 3'h4 &&
    CMD_CHAN inside {4'h2, 4'h5, 4'h7, 4'h9, 4'hA, 4'hB} |=> CMD_CONFLICT)
    else $error("quadrature across blocks accepted");
  AST_IRQ_CAUSE: assert property (|IN_IRQ |-> age_q inside {[4'h1:4'h6]})
    else $error("interrupt without recent pin edge");
  AST_CLR_ZERO: assert property (s_clr |=> RD_COUNT == 16'h0000 && !RD_CAP_DONE)
    else $error("clear left count standing");
  AST_WAIT_TRIG: assert property (s_cfg2 ##0 !OUT_TRIG[1] |=> OUT_OE_B[2])
    else $error("output ran before trigger");
endmodule

// ---- tb/iocp_field.sv ----
// Field side model: input signal sources and pulled-up sinking loads
`timescale 1ns/10ps
module iocp_field (
  input logic CLK,
  input logic [7:0] OUT_OE_B,
  input logic [7:0] OUT_DO,
  output logic [11:0] pins,
  output logic [7:0] line
);
  // Pull-down setting: quiet inputs sit low
  initial pins = 12'h000;
  // Load pulls a released line high; a sinking line follows data
  assign line = OUT_OE_B | OUT_DO;
  // One level change, held long enough for sync and readback
  task pin(input int ch, input logic v);
    @(posedge CLK);
    pins[ch] <= v;
    repeat (6) @(posedge CLK);
  endtask
  // High then low pulse on one input
  task pulse(input int ch);
    pin(ch, 1'b1);
    pin(ch, 1'b0);
  endtask
endmodule

// ---- tb/iocp_top_tb_top.sv ----
// Self-checking bench for the counter and modulation core
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module iocp_top_tb_top;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic CMD_VALID = 1'b0;
  logic CE = 1'b1;
  logic CMD_INDEX = 1'b0;
  logic [1:0] CMD_OP = 2'h0;
  logic [3:0] CMD_CHAN = 4'h0;
  logic [2:0] CMD_MODE = 3'h0;
  logic [1:0] CMD_EDGE = 2'h0;
  logic CMD_DOWN = 1'b0;
  logic CMD_INV = 1'b0;
  logic [3:0] CMD_STOP = 4'hF;
  logic [15:0] CMD_PERIOD = 16'h0000;
  logic [15:0] CMD_DUTY = 16'h0000;
  logic [15:0] CMD_OFFSET = 16'h0000;
  logic [3:0] OUT_TRIG = 4'h0;
  logic [3:0] RD_CHAN = 4'h0;
  wire CMD_DONE, CMD_CONFLICT, RD_CAP_DONE;
  wire [11:0] IN_IRQ, IN_PIN;
  wire [15:0] RD_COUNT, RD_BEGIN, RD_END;
  wire [7:0] OUT_DO, OUT_OE_B, line;
  int bad_count = 0;
  int n_compared = 0;
  int irq_n = 0;
  int e, n;
  int fst [8];
  int low [8];
  // Free-running 100 MHz clock
  always #5 CLK = ~CLK;
  iocp_top DUT (.CLK(CLK), .CE(CE), .RST_B(RST_B), .IN_PIN(IN_PIN), .CMD_VALID(CMD_VALID),
    .CMD_OP(CMD_OP), .CMD_CHAN(CMD_CHAN), .CMD_MODE(CMD_MODE), .CMD_EDGE(CMD_EDGE),
    .CMD_DOWN(CMD_DOWN), .CMD_INDEX(CMD_INDEX), .CMD_STOP(CMD_STOP), .CMD_INV(CMD_INV),
    .CMD_PERIOD(CMD_PERIOD), .CMD_DUTY(CMD_DUTY), .CMD_OFFSET(CMD_OFFSET), .OUT_TRIG(OUT_TRIG),
    .RD_CHAN(RD_CHAN), .CMD_DONE(CMD_DONE), .CMD_CONFLICT(CMD_CONFLICT), .IN_IRQ(IN_IRQ),
    .RD_COUNT(RD_COUNT), .RD_BEGIN(RD_BEGIN), .RD_END(RD_END), .RD_CAP_DONE(RD_CAP_DONE),
    .OUT_DO(OUT_DO), .OUT_OE_B(OUT_OE_B));
  iocp_field FLD (.CLK(CLK), .OUT_OE_B(OUT_OE_B), .OUT_DO(OUT_DO), .pins(IN_PIN), .line(line));
  // Tally of interrupt pulses on input 0
  always @(posedge CLK) if (IN_IRQ[0] === 1'b1) irq_n <= irq_n + 1;
  // Verdict and end of run
  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One command strobe, then check which answer came back
  task go(input [1:0] op, input [3:0] ch, input [2:0] md, input cf);
    @(posedge CLK);
    CMD_VALID <= 1'b1;
    CMD_OP <= op;
    CMD_CHAN <= ch;
    CMD_MODE <= md;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    #1;
    `CHK("conflict", cf, CMD_CONFLICT)
    `CHK("done", !cf, CMD_DONE)
  endtask
  // Input configure with edge select and direction
  task cin(input [3:0] ch, input [2:0] md, input [1:0] ed, input dn, input cf);
    @(posedge CLK);
    CMD_EDGE <= ed;
    CMD_DOWN <= dn;
    go(2'h0, ch, md, cf);
  endtask
  // Output configure with waveform timing
  task cout(input [3:0] ch, input [2:0] md, input iv, input [15:0] pe, input [15:0] du,
    input [15:0] of, input cf);
    @(posedge CLK);
    CMD_INV <= iv;
    CMD_PERIOD <= pe;
    CMD_DUTY <= du;
    CMD_OFFSET <= of;
    go(2'h1, ch, md, cf);
  endtask
  // Select a channel and let the registered view settle
  task rd(input [3:0] ch);
    @(posedge CLK);
    RD_CHAN <= ch;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  // Trigger blocks 3 and 4 together; note first sink and sinks per period
  task wave;
    int i, b;
    for (b = 0; b < 8; b++) begin
      fst[b] = -1;
      low[b] = 0;
    end
    @(posedge CLK);
    OUT_TRIG <= 4'h6;
    @(posedge CLK);
    OUT_TRIG <= 4'h0;
    for (i = 0; i < 40; i++) begin
      #1;
      for (b = 0; b < 8; b++) begin
        if (line[b] === 1'b0 && fst[b] < 0) fst[b] = i;
        if (line[b] === 1'b0 && i >= 20 && i < 30) low[b]++;
      end
      @(posedge CLK);
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    #1;
    `CHK("oe after reset", 8'hFF, OUT_OE_B)
    `CHK("lines idle", 8'hFF, line)
    cin(4'h3, 3'h2, 2'h1, 1'b0, 1'b0);
    repeat (3) FLD.pulse(3);
    rd(4'h3);
    `CHK("up count", 16'h0003, RD_COUNT)
    cin(4'h4, 3'h2, 2'h3, 1'b1, 1'b0);
    FLD.pulse(4);
    rd(4'h4);
    `CHK("down count", 16'hFFFE, RD_COUNT)
    go(2'h2, 4'h4, 3'h0, 1'b0);
    rd(4'h4);
    `CHK("cleared", 16'h0000, RD_COUNT)
    // Clock enable low: a whole pulse must leave no trace
    @(posedge CLK);
    CE <= 1'b0;
    FLD.pulse(4);
    CE <= 1'b1;
    rd(4'h4);
    `CHK("frozen count", 16'h0000, RD_COUNT)
    for (e = 1; e < 4; e++) begin
      cin(4'h0, 3'h1, e[1:0], 1'b0, 1'b0);
      n = irq_n;
      FLD.pulse(0);
      `CHK("irq pulses", (e == 3) ? 2 : 1, irq_n - n)
    end
    CMD_STOP <= 4'h2;
    cin(4'h1, 3'h3, 2'h1, 1'b0, 1'b0);
    FLD.pin(1, 1'b1);
    FLD.pin(2, 1'b1);
    rd(4'h1);
    `CHK("stamp span", 16'h0007, RD_END - RD_BEGIN)
    `CHK("capture done", 1'b1, RD_CAP_DONE)
    cin(4'h3, 3'h4, 2'h1, 1'b0, 1'b1);
    cin(4'h9, 3'h4, 2'h1, 1'b0, 1'b1);
    cin(4'hC, 3'h2, 2'h1, 1'b0, 1'b1);
    go(2'h3, 4'h0, 3'h0, 1'b1);
    cout(4'h8, 3'h2, 1'b0, 16'h000A, 16'h0003, 16'h0000, 1'b1);
    cin(4'h6, 3'h4, 2'h1, 1'b0, 1'b0);
    FLD.pin(6, 1'b1);
    FLD.pin(7, 1'b1);
    FLD.pin(6, 1'b0);
    FLD.pin(7, 1'b0);
    rd(4'h6);
    `CHK("quad count", 16'h0004, RD_COUNT)
    // Index pin must share the block too
    CMD_INDEX <= 1'b1;
    cin(4'h6, 3'h4, 2'h1, 1'b0, 1'b1);
    cin(4'h3, 3'h0, 2'h1, 1'b0, 1'b0);
    cin(4'h4, 3'h0, 2'h1, 1'b0, 1'b0);
    cin(4'h3, 3'h4, 2'h1, 1'b0, 1'b0);
    FLD.pin(3, 1'b1);
    rd(4'h3);
    `CHK("quad index step", 16'h0001, RD_COUNT)
    FLD.pin(5, 1'b1);
    rd(4'h3);
    `CHK("quad index clear", 16'h0000, RD_COUNT)
    CMD_INDEX <= 1'b0;
    cout(4'h0, 3'h2, 1'b0, 16'h000A, 16'h0003, 16'h0000, 1'b1);
    cout(4'h2, 3'h2, 1'b0, 16'h000A, 16'h0003, 16'h0000, 1'b0);
    cout(4'h3, 3'h2, 1'b1, 16'h000C, 16'h0003, 16'h0000, 1'b1);
    cout(4'h3, 3'h2, 1'b1, 16'h000A, 16'h0003, 16'h0000, 1'b0);
    cout(4'h4, 3'h3, 1'b0, 16'h000A, 16'h0003, 16'h0002, 1'b0);
    cout(4'h5, 3'h3, 1'b1, 16'h000A, 16'h0003, 16'h0002, 1'b0);
    `CHK("held before trigger", 8'hFF, OUT_OE_B)
    wave;
    `CHK("noninv sink span", 3, low[2])
    `CHK("inv sink span", 7, low[3])
    `CHK("pos mod span", 3, low[4])
    `CHK("inv pos mod span", 7, low[5])
    `CHK("inv edge align", 3, fst[3] - fst[2])
    `CHK("pos mod offset", 2, fst[4] - fst[2])
    cout(4'h6, 3'h1, 1'b1, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    repeat (2) @(posedge CLK);
    #1;
    `CHK("static sink", 1'b0, line[6])
    stop_test;
  end
  // Watchdog far beyond the expected run length
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
endmodule
bind iocp_top iocp_chk MON (.CLK(CLK), .CE(CE), .RST_B(RST_B), .IN_PIN(IN_PIN), .CMD_VALID(CMD_VALID),
  .CMD_OP(CMD_OP), .CMD_CHAN(CMD_CHAN), .CMD_MODE(CMD_MODE), .OUT_TRIG(OUT_TRIG), .RD_CHAN(RD_CHAN),
  .CMD_DONE(CMD_DONE), .CMD_CONFLICT(CMD_CONFLICT), .IN_IRQ(IN_IRQ), .RD_COUNT(RD_COUNT),
  .RD_CAP_DONE(RD_CAP_DONE), .OUT_DO(OUT_DO), .OUT_OE_B(OUT_OE_B));
